/* common/iosfb_map.svh */
`ifndef IOSFB_MAP_SVH
`define IOSFB_MAP_SVH

`define IOSFB_START_DELIM   8'h7E
`define IOSFB_FRAME_TYPE    8'h92
`define IOSFB_OFF_LEN       5'h01
`define IOSFB_OFF_TYPE      5'h03
`define IOSFB_OFF_SRC64     5'h04
`define IOSFB_OFF_SRC16     5'h0C
`define IOSFB_OFF_RXOPT     5'h0E
`define IOSFB_OFF_NSAMP     5'h0F
`define IOSFB_OFF_DMASK     5'h10
`define IOSFB_OFF_AMASK     5'h12
`define IOSFB_HEAD_LAST     5'h12
`define IOSFB_CKSUM_FIRST   5'h03
`define IOSFB_CKSUM_BASE    8'hFF
`define IOSFB_FIXED_LEN     16'h0010
`define IOSFB_DIG_LEN       16'h0002
`define IOSFB_ANA_LEN       16'h0002
`define IOSFB_DLINE_VALID   16'h7FFF
`define IOSFB_AMASK_VALID   8'h8F
`define IOSFB_SUPPLY_BIT    7
`define IOSFB_SUPPLY_CHAN   3'h4
`define IOSFB_NO_CHAN       3'h5
`define IOSFB_AO_STANDARD   8'h00
`define IOSFB_FIFO_DEPTH    32

`endif

/* common/iosfb_pkg.sv */
`default_nettype none

package iosfb_pkg;

  typedef struct packed {
    logic [63:0]      src_addr;
    logic [15:0]      net_addr;
    logic [7:0]       rx_options;
    logic [7:0]       num_samples;
    logic [15:0]      line_mask;
    logic [7:0]       chan_mask;
    logic [15:0]      line_samples;
    logic [4:0][15:0] analog;
  } iosfb_sample_type;

  typedef enum logic [2:0] {
    IOSFB_IDLE,
    IOSFB_HEAD,
    IOSFB_DIG,
    IOSFB_ANA,
    IOSFB_SUM
  } iosfb_state_type;

endpackage : iosfb_pkg

`default_nettype wire

/* rtl/iosfb_fifo.sv */
`timescale 1ns/100ps
`default_nettype none

module iosfb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;
  logic             wr_en;
  logic             rd_en;

  // The output stage is a register, so the consumer never sees memory read timing.
  assign in_ready_out  = (count_reg != (AW+1)'(DEPTH));
  assign wr_en         = in_valid_in && in_ready_out;
  assign rd_en         = (count_reg != '0) && (!out_valid_reg || out_ready_in);
  assign out_valid_out = out_valid_reg;
  assign out_data_out  = out_data_reg;

  always_ff @(posedge clk_in) begin
    if (wr_en) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (wr_en) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (rd_en) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(wr_en) - (AW+1)'(rd_en);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end else if (rd_en) begin
      out_valid_reg <= 1'b1;
      out_data_reg  <= mem[rd_ptr_reg];
    end else if (out_ready_in) begin
      out_valid_reg <= 1'b0;
    end
  end

endmodule : iosfb_fifo

`default_nettype wire

/* rtl/iosfb_top.sv */
// What this block does
// - Digital line mask, 16 bits, sits at offset 16; bit 15 unused.
// - Analog channel mask, 8 bits, sits at offset 18; bits 0-3 flag inputs.
// - Mask bit 7 flags that a supply voltage reading is included.
// - Digital sample word is sent only when the line mask is nonzero.
// - Sample bits of lines without sampling enabled read as zero.
// - Sample word bit positions match line mask bit positions.
// - One 16-bit reading per enabled analog input, after any sample word.
// - Readings go in ascending channel order, disabled channels skipped.
// - Checksum is 0xFF minus low byte of sum from offset 3 onward.
// - Frame type code 0x92 stands at offset 3.
// - Length field counts bytes between length field and checksum.
// - Frames leave only in API mode with standard output option.
// - Sample set count sits in an 8-bit field at offset 15.
`include "iosfb_map.svh"
`timescale 1ns/100ps
`default_nettype none

module iosfb_top
  import iosfb_pkg::*;
#(
  parameter int FIFO_DEPTH = `IOSFB_FIFO_DEPTH
) (
  input  wire logic             CLK_IN,
  input  wire logic             RESETN_IN,
  input  wire logic             API_MODE_IN,
  input  wire logic [7:0]       API_OUTPUT_OPTION_IN,
  input  wire logic             REQ_VALID_IN,
  input  wire iosfb_sample_type REQ_DATA_IN,
  output logic                  REQ_READY_OUT,
  output logic                  TX_VALID_OUT,
  output logic [7:0]            TX_BYTE_OUT,
  input  wire logic             TX_READY_IN,
  output logic                  FRAME_DONE_OUT,
  output logic                  DROPPED_OUT
);

  iosfb_state_type  state_reg;
  iosfb_sample_type req_reg;
  logic [4:0]       idx_reg;
  logic [2:0]       chan_reg;
  logic             lo_reg;
  logic [7:0]       sum_reg;
  logic [15:0]      len_reg;
  logic             ready_reg;
  logic             done_reg;
  logic             drop_reg;
  logic             fifo_ready;
  logic             emit;
  logic [7:0]       cur_byte;
  logic [15:0]      dig_w;
  logic             accept;

  function automatic logic chan_on(input logic [7:0] mask, input logic [2:0] ch);
    if (ch == `IOSFB_SUPPLY_CHAN) begin
      chan_on = mask[`IOSFB_SUPPLY_BIT];
    end else begin
      chan_on = (ch < `IOSFB_SUPPLY_CHAN) && mask[ch[1:0]];
    end
  endfunction : chan_on

  // First enabled channel at or above the start; no channel left gives the end marker.
  function automatic logic [2:0] next_chan(input logic [7:0] mask, input logic [2:0] from);
    next_chan = `IOSFB_NO_CHAN;
    for (int c = 4; c >= 0; c--) begin
      if ((3'(c) >= from) && chan_on(mask, 3'(c))) begin
        next_chan = 3'(c);
      end
    end
  endfunction : next_chan

  function automatic logic [15:0] frame_len(input iosfb_sample_type r);
    frame_len = `IOSFB_FIXED_LEN;
    if ((r.line_mask & `IOSFB_DLINE_VALID) != 16'h0000) begin
      frame_len = frame_len + `IOSFB_DIG_LEN;
    end
    for (int c = 0; c < 5; c++) begin
      if (chan_on(r.chan_mask, 3'(c))) begin
        frame_len = frame_len + `IOSFB_ANA_LEN;
      end
    end
  endfunction : frame_len

  function automatic logic [7:0] head_byte(input logic [4:0] idx, input iosfb_sample_type r,
                                           input logic [15:0] len);
    logic [15:0] dmask;
    dmask = r.line_mask & `IOSFB_DLINE_VALID;
    head_byte = 8'h00;
    case (idx)
      5'h00:   head_byte = `IOSFB_START_DELIM;
      `IOSFB_OFF_LEN:   head_byte = len[15:8];
      5'h02:   head_byte = len[7:0];
      `IOSFB_OFF_TYPE:  head_byte = `IOSFB_FRAME_TYPE;
      `IOSFB_OFF_SRC16: head_byte = r.net_addr[15:8];
      5'h0D:   head_byte = r.net_addr[7:0];
      `IOSFB_OFF_RXOPT: head_byte = r.rx_options;
      `IOSFB_OFF_NSAMP: head_byte = r.num_samples;
      `IOSFB_OFF_DMASK: head_byte = dmask[15:8];
      5'h11:   head_byte = dmask[7:0];
      `IOSFB_OFF_AMASK: head_byte = r.chan_mask & `IOSFB_AMASK_VALID;
      default: begin
        if (idx >= `IOSFB_OFF_SRC64 && idx < `IOSFB_OFF_SRC16) begin
          head_byte = r.src_addr[8*(11-int'(idx)) +: 8];
        end
      end
    endcase
  endfunction : head_byte

  // Unsampled and unused lines are forced low regardless of what the source left there.
  function automatic logic [15:0] dig_word(input iosfb_sample_type r);
    dig_word = r.line_samples & r.line_mask & `IOSFB_DLINE_VALID;
  endfunction : dig_word

  assign accept = ready_reg && REQ_VALID_IN;
  assign emit   = (state_reg != IOSFB_IDLE) && fifo_ready;
  assign dig_w  = dig_word(req_reg);

  always_comb begin
    cur_byte = 8'h00;
    case (state_reg)
      IOSFB_HEAD: cur_byte = head_byte(idx_reg, req_reg, len_reg);
      IOSFB_DIG:  cur_byte = lo_reg ? dig_w[7:0] : dig_w[15:8];
      IOSFB_ANA:  cur_byte = lo_reg ? req_reg.analog[chan_reg][7:0] : req_reg.analog[chan_reg][15:8];
      IOSFB_SUM:  cur_byte = `IOSFB_CKSUM_BASE - sum_reg;
      default:    cur_byte = 8'h00;
    endcase
  end

  // Once a frame has started, the sequencer only advances when the FIFO has room, so a stalled port holds it.
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_reg <= IOSFB_IDLE;
      idx_reg   <= 5'h00;
      chan_reg  <= 3'h0;
      lo_reg    <= 1'b0;
    end else begin
      case (state_reg)
        IOSFB_IDLE: begin
          idx_reg <= 5'h00;
          lo_reg  <= 1'b0;
          if (accept && API_MODE_IN && (API_OUTPUT_OPTION_IN == `IOSFB_AO_STANDARD)) begin
            state_reg <= IOSFB_HEAD;
          end
        end
        IOSFB_HEAD: begin
          if (emit) begin
            idx_reg <= idx_reg + 5'h01;
            if (idx_reg == `IOSFB_HEAD_LAST) begin
              chan_reg <= next_chan(req_reg.chan_mask, 3'h0);
              // The host sees only the mask as sent, so a mask with just the unused bit carries no word.
              if ((req_reg.line_mask & `IOSFB_DLINE_VALID) != 16'h0000) begin
                state_reg <= IOSFB_DIG;
              end else if (next_chan(req_reg.chan_mask, 3'h0) != `IOSFB_NO_CHAN) begin
                state_reg <= IOSFB_ANA;
              end else begin
                state_reg <= IOSFB_SUM;
              end
            end
          end
        end
        IOSFB_DIG: begin
          if (emit) begin
            lo_reg <= ~lo_reg;
            if (lo_reg) begin
              state_reg <= (chan_reg != `IOSFB_NO_CHAN) ? IOSFB_ANA : IOSFB_SUM;
            end
          end
        end
        IOSFB_ANA: begin
          if (emit) begin
            lo_reg <= ~lo_reg;
            if (lo_reg) begin
              chan_reg <= next_chan(req_reg.chan_mask, chan_reg + 3'h1);
              if (next_chan(req_reg.chan_mask, chan_reg + 3'h1) == `IOSFB_NO_CHAN) begin
                state_reg <= IOSFB_SUM;
              end
            end
          end
        end
        IOSFB_SUM: begin
          if (emit) begin
            state_reg <= IOSFB_IDLE;
          end
        end
        default: state_reg <= IOSFB_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      req_reg <= '0;
      len_reg <= 16'h0000;
    end else if (accept) begin
      req_reg <= REQ_DATA_IN;
      len_reg <= frame_len(REQ_DATA_IN);
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sum_reg <= 8'h00;
    end else if (state_reg == IOSFB_IDLE) begin
      sum_reg <= 8'h00;
    end else if (emit && (state_reg != IOSFB_SUM)) begin
      if (state_reg != IOSFB_HEAD || idx_reg >= `IOSFB_CKSUM_FIRST) begin
        sum_reg <= sum_reg + cur_byte;
      end
    end
  end

  // Ready drops the cycle after a request is taken, so only one frame is in flight.
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ready_reg <= 1'b0;
      done_reg  <= 1'b0;
      drop_reg  <= 1'b0;
    end else begin
      ready_reg <= (state_reg == IOSFB_IDLE && !accept) || (state_reg == IOSFB_SUM && emit);
      done_reg  <= (state_reg == IOSFB_SUM) && emit;
      drop_reg  <= accept && !(API_MODE_IN && (API_OUTPUT_OPTION_IN == `IOSFB_AO_STANDARD));
    end
  end

  assign REQ_READY_OUT  = ready_reg;
  assign FRAME_DONE_OUT = done_reg;
  assign DROPPED_OUT    = drop_reg;

  iosfb_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (CLK_IN),
    .resetn_in     (RESETN_IN),
    .in_valid_in   (emit),
    .in_ready_out  (fifo_ready),
    .in_data_in    (cur_byte),
    .out_valid_out (TX_VALID_OUT),
    .out_ready_in  (TX_READY_IN),
    .out_data_out  (TX_BYTE_OUT)
  );

endmodule : iosfb_top

`default_nettype wire

/* testbench/iosfb_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module iosfb_monitor
  import iosfb_pkg::*;
(
  input wire logic       CLK_IN,
  input wire logic       RESETN_IN,
  input wire logic       API_MODE_IN,
  input wire logic [7:0] API_OUTPUT_OPTION_IN,
  input wire logic       REQ_VALID_IN,
  input wire logic       REQ_READY_OUT,
  input wire logic       TX_VALID_OUT,
  input wire logic [7:0] TX_BYTE_OUT,
  input wire logic       TX_READY_IN,
  input wire logic       DROPPED_OUT
);
  // Frame position is rebuilt from the byte stream alone, so no inside state is trusted.
  logic [15:0] pos_reg;
  logic [15:0] len_reg;
  logic [7:0]  sum_reg;
  logic        dnz_reg;
  wire         acc = TX_VALID_OUT && TX_READY_IN;
  wire         req = REQ_VALID_IN && REQ_READY_OUT;
  wire         ok  = API_MODE_IN && API_OUTPUT_OPTION_IN == 8'h00;
  wire         eof = pos_reg > 16'h0002 && pos_reg == len_reg + 16'h0003;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      pos_reg <= 16'h0000;
      len_reg <= 16'h0000;
      sum_reg <= 8'h00;
      dnz_reg <= 1'b0;
    end else if (acc) begin
      pos_reg <= eof ? 16'h0000 : pos_reg + 16'h0001;
      sum_reg <= (pos_reg < 16'h0003) ? 8'h00 : sum_reg + TX_BYTE_OUT;
      if (pos_reg == 16'h0001) len_reg[15:8] <= TX_BYTE_OUT;
      if (pos_reg == 16'h0002) len_reg[7:0] <= TX_BYTE_OUT;
      if (pos_reg == 16'h0010) dnz_reg <= |TX_BYTE_OUT;
      if (pos_reg == 16'h0011) dnz_reg <= dnz_reg | (|TX_BYTE_OUT);
    end
  end
  a_drop_refused: assert property (req && !ok |=> DROPPED_OUT)
    else $error("refused request gave no drop pulse");
  a_drop_quiet: assert property (req && !ok && !TX_VALID_OUT |=> !TX_VALID_OUT [*3])
    else $error("refused request produced bytes");
  // Take, push into the buffer, load its output register: the delimiter is seen on the third edge.
  a_frame_start: assert property (req && ok && !TX_VALID_OUT |-> ##3 TX_VALID_OUT && TX_BYTE_OUT == 8'h7E)
    else $error("frame did not start three cycles after take");
  a_first_delim: assert property (acc && pos_reg == 16'h0000 |-> TX_BYTE_OUT == 8'h7E)
    else $error("frame does not open with delimiter");
  a_stall_hold: assert property (TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_BYTE_OUT))
    else $error("byte changed while stalled");
  a_type_code: assert property (acc && pos_reg == 16'h0003 |-> TX_BYTE_OUT == 8'h92)
    else $error("wrong frame type");
  a_line_bit15: assert property (acc && pos_reg == 16'h0010 |-> !TX_BYTE_OUT[7])
    else $error("line mask bit 15 set");
  a_chan_spare: assert property (acc && pos_reg == 16'h0012 |-> TX_BYTE_OUT[6:4] == 3'h0)
    else $error("channel mask spare bits set");
  a_length_masks: assert property (acc && pos_reg == 16'h0012 |-> len_reg == 16'h0010
    + (dnz_reg ? 16'h0002 : 16'h0000) + 16'($countones(TX_BYTE_OUT & 8'h8F)) * 16'h0002)
    else $error("length disagrees with masks");
  a_sum_check: assert property (acc && eof |-> sum_reg + TX_BYTE_OUT == 8'hFF)
    else $error("bad checksum");
  c_frame: cover property (req && ok);
  c_drop: cover property (DROPPED_OUT);
  c_stall: cover property ((TX_VALID_OUT && !TX_READY_IN) [*3]);
  c_digital: cover property (acc && pos_reg == 16'h0012 && dnz_reg);
endmodule : iosfb_monitor
bind iosfb_top iosfb_monitor mon (
  .CLK_IN               (CLK_IN),
  .RESETN_IN            (RESETN_IN),
  .API_MODE_IN          (API_MODE_IN),
  .API_OUTPUT_OPTION_IN (API_OUTPUT_OPTION_IN),
  .REQ_VALID_IN         (REQ_VALID_IN),
  .REQ_READY_OUT        (REQ_READY_OUT),
  .TX_VALID_OUT         (TX_VALID_OUT),
  .TX_BYTE_OUT          (TX_BYTE_OUT),
  .TX_READY_IN          (TX_READY_IN),
  .DROPPED_OUT          (DROPPED_OUT)
);
`default_nettype wire

/* testbench/iosfb_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module iosfb_host_model (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       valid_in,
  input  wire logic [7:0] byte_in,
  input  wire logic [1:0] mode_in,
  output logic            ready_out,
  output logic [7:0]      rx_out [256],
  output logic [7:0]      count_out,
  output logic            good_out
);
  // Mode 0 takes every byte, mode 1 every other cycle, mode 2 stalls outright.
  logic [15:0] pos_reg;
  logic [15:0] len_reg;
  logic [7:0]  sum_reg;
  logic [7:0]  amask_reg;
  logic        dig_reg;
  wire         eof = pos_reg > 16'h0002 && pos_reg == len_reg + 16'h0003;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ready_out <= 1'b0;
      count_out <= 8'h00;
      good_out <= 1'b0;
      pos_reg <= 16'h0000;
      len_reg <= 16'h0000;
      sum_reg <= 8'h00;
      amask_reg <= 8'h00;
      dig_reg <= 1'b0;
    end else begin
      ready_out <= mode_in == 2'h0 || (mode_in == 2'h1 && !ready_out);
      if (valid_in && ready_out) begin
        rx_out[count_out] <= byte_in;
        count_out <= count_out + 8'h01;
        pos_reg <= eof ? 16'h0000 : pos_reg + 16'h0001;
        sum_reg <= (pos_reg < 16'h0003) ? 8'h00 : sum_reg + byte_in;
        if (pos_reg == 16'h0000) good_out <= 1'b0;
        if (pos_reg == 16'h0001) len_reg[15:8] <= byte_in;
        if (pos_reg == 16'h0002) len_reg[7:0] <= byte_in;
        if (pos_reg == 16'h0010) dig_reg <= |byte_in;
        if (pos_reg == 16'h0011) dig_reg <= dig_reg | (|byte_in);
        if (pos_reg == 16'h0012) amask_reg <= byte_in;
        // Optional fields are sized from the masks before the checksum is trusted.
        if (eof) good_out <= sum_reg + byte_in == 8'hFF && len_reg == 16'h0010
          + (dig_reg ? 16'h0002 : 16'h0000) + 16'($countones(amask_reg & 8'h8F)) * 16'h0002;
      end
    end
  end
endmodule : iosfb_host_model
`default_nettype wire

/* testbench/tb_iosfb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_iosfb_top
  import iosfb_pkg::*;
;
  logic             CLK_IN, RESETN_IN, API_MODE_IN, REQ_VALID_IN, TX_READY_IN, good;
  logic             REQ_READY_OUT, TX_VALID_OUT, FRAME_DONE_OUT, DROPPED_OUT;
  logic [7:0]       API_OUTPUT_OPTION_IN, TX_BYTE_OUT, count;
  logic [7:0]       rx [256];
  logic [7:0]       q [$];
  logic [1:0]       mode;
  iosfb_sample_type REQ_DATA_IN;
  int               mismatches, n_compared;
  int               n_done = 0;
  // Done pulses are counted here so a stuck or missing pulse shows up on every frame.
  always @(posedge CLK_IN) if (FRAME_DONE_OUT === 1'b1) n_done <= n_done + 1;
  // A shallow buffer lets a modest frame fill it and stall the sequencer.
  iosfb_top #(.FIFO_DEPTH(8)) uut (.*);
  iosfb_host_model host (.clk_in(CLK_IN), .resetn_in(RESETN_IN), .valid_in(TX_VALID_OUT), .byte_in(TX_BYTE_OUT),
    .mode_in(mode), .ready_out(TX_READY_IN), .rx_out(rx), .count_out(count), .good_out(good));
  initial begin
    CLK_IN = 1'b0;
    forever #20 CLK_IN = ~CLK_IN;
  end
  // The whole run needs well under a thousand cycles; ten thousand means a hang.
  initial begin
    #400000;
    mismatches++;
    stop_test();
  end
  task automatic stop_test();
    if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  function automatic void p16(logic [15:0] v);
    q.push_back(v[15:8]);
    q.push_back(v[7:0]);
  endfunction : p16
  function automatic void build(iosfb_sample_type s);
    logic [15:0] lm;
    logic [7:0]  ck;
    lm = s.line_mask & 16'h7FFF;
    q = {8'h92};
    for (int i = 7; i >= 0; i--) q.push_back(s.src_addr[i*8 +: 8]);
    p16(s.net_addr);
    q.push_back(s.rx_options);
    q.push_back(s.num_samples);
    p16(lm);
    q.push_back(s.chan_mask & 8'h8F);
    if (lm != 16'h0000) p16(s.line_samples & lm);
    for (int c = 0; c < 5; c++) if (s.chan_mask[c == 4 ? 7 : c]) p16(s.analog[c]);
    ck = 8'hFF;
    foreach (q[i]) ck -= q[i];
    lm = 16'(q.size());
    q.push_back(ck);
    q.push_front(lm[7:0]);
    q.push_front(lm[15:8]);
    q.push_front(8'h7E);
  endfunction : build
  task automatic send(iosfb_sample_type s, logic api, logic [7:0] opt);
    int n;
    n = 0;
    while (REQ_READY_OUT !== 1'b1 && n < 500) begin
      @(negedge CLK_IN);
      n++;
    end
    @(posedge CLK_IN);
    REQ_VALID_IN <= 1'b1;
    REQ_DATA_IN <= s;
    API_MODE_IN <= api;
    API_OUTPUT_OPTION_IN <= opt;
    @(posedge CLK_IN);
    REQ_VALID_IN <= 1'b0;
    @(negedge CLK_IN);
  endtask : send
  task automatic frame(iosfb_sample_type s, logic [1:0] m, bit stall);
    logic [7:0] base;
    int         n;
    int         done0;
    base = count;
    done0 = n_done;
    build(s);
    mode <= stall ? 2'h2 : m;
    send(s, 1'b1, 8'h00);
    if (stall) begin
      repeat (60) @(negedge CLK_IN);
      cmp("ready while stalled", 16'h0000, REQ_READY_OUT);
      cmp("valid while stalled", 16'h0001, TX_VALID_OUT);
      mode <= m;
    end
    n = 0;
    while (count - base != 8'(q.size()) && n < 500) begin
      @(negedge CLK_IN);
      n++;
    end
    foreach (q[i]) cmp("frame byte", q[i], rx[8'(base + i)]);
    cmp("host check", 16'h0001, good);
    cmp("frame done pulses", 16'(done0 + 1), 16'(n_done));
  endtask : frame
  task automatic t_example();
    iosfb_sample_type s;
    s = '0;
    s.src_addr = 64'h0013A20012345678;
    s.net_addr = 16'h87AC;
    s.rx_options = 8'h01;
    s.num_samples = 8'h01;
    s.line_mask = 16'h0038;
    s.chan_mask = 8'h06;
    s.line_samples = 16'h0028;
    s.analog = {16'h5555, 16'hDEAD, 16'h00F8, 16'h0225, 16'hBEEF};
    frame(s, 2'h0, 1'b0);
    cmp("example checksum", 16'h00EA, rx[8'(count - 1)]);
    cmp("example length", 16'h0016, {rx[8'(count - 25)], rx[8'(count - 24)]});
  endtask : t_example
  task automatic t_analog();
    iosfb_sample_type s;
    s = '0;
    s.src_addr = 64'h0102030405060708;
    s.chan_mask = 8'hFF;
    s.line_samples = 16'hFFFF;
    s.analog = {16'h5555, 16'h4444, 16'h3333, 16'h2222, 16'h1111};
    frame(s, 2'h1, 1'b0);
  endtask : t_analog
  task automatic t_lines();
    iosfb_sample_type s;
    s = '0;
    s.num_samples = 8'h02;
    s.line_mask = 16'hC005;
    s.line_samples = 16'hFFFF;
    s.analog = {16'h5555, 16'h4444, 16'h3333, 16'h2222, 16'h1111};
    frame(s, 2'h0, 1'b1);
  endtask : t_lines
  task automatic t_refuse();
    iosfb_sample_type s;
    logic [7:0]       base;
    s = '0;
    s.line_mask = 16'h0001;
    for (int k = 0; k < 2; k++) begin
      base = count;
      send(s, k[0], {7'h00, k[0]});
      cmp("drop pulse", 16'h0001, DROPPED_OUT);
      repeat (5) @(negedge CLK_IN);
      cmp("bytes after drop", base, count);
    end
  endtask : t_refuse
  initial begin
    RESETN_IN = 1'b0;
    REQ_VALID_IN = 1'b0;
    API_MODE_IN = 1'b1;
    API_OUTPUT_OPTION_IN = 8'h00;
    REQ_DATA_IN = '0;
    mode = 2'h0;
    mismatches = 0;
    n_compared = 0;
    repeat (2) @(posedge CLK_IN);
    RESETN_IN <= 1'b1;
    @(negedge CLK_IN);
    t_example();
    t_analog();
    t_lines();
    t_refuse();
    stop_test();
  end
endmodule : tb_iosfb_top
`default_nettype wire
